/* File: hw/ses_pkg.sv */
// Package for the shutter exposure sequencer: register map, field layout, reset values,
// line-shift and overhead tables, state codes and the configuration carrier.
// Assumes a 100 MHz bus clock and 32-bit AHB-Lite register access.
package ses_pkg;

  // ==========================================================================
  // Clock and time units
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US = 1000;
  localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_EXPOSURE = 8'h04;
  localparam logic [7:0] ADDR_HEIGHT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_SENSOR_RO = 8'h10;
  localparam logic [7:0] ADDR_TOTAL_RO = 8'h14;
  localparam logic [7:0] ADDR_RESET_RT = 8'h18;
  localparam logic [7:0] ADDR_TOTAL_RT = 8'h1C;

  // ==========================================================================
  // Field positions
  localparam int CTRL_GLOBAL_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_WIDTH_BIT = 2;
  localparam int CTRL_TRIG_BIT = 3;
  localparam int CTRL_FMT_LSB = 4;
  localparam int CTRL_VAR_LSB = 6;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_EXP_BIT = 1;
  localparam int STAT_FLASH_BIT = 2;
  localparam int STAT_MISS_BIT = 3;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [19:0] EXPOSURE_RST = 20'h0_0BB8;
  localparam logic [11:0] HEIGHT_RST = 12'h400;

  // ==========================================================================
  // Line-shift interval per variant and format, in ns
  localparam logic [15:0] SHIFT_FIXED_NS = 16'd35000;
  localparam logic [15:0] SHIFT_B8_NS = 16'd24725;
  localparam logic [15:0] SHIFT_B12_NS = 16'd30975;
  localparam logic [15:0] SHIFT_B12P_NS = 16'd28475;
  localparam logic [15:0] SHIFT_C8_NS = 16'd30750;
  localparam logic [15:0] SHIFT_C12_NS = 16'd37000;
  localparam logic [15:0] SHIFT_C12P_NS = 16'd33875;

  // Exposure overhead per mode, variant and format, in us
  localparam logic [15:0] OVH_LS_FIXED_US = 16'd490;
  localparam logic [15:0] OVH_LS_B8_US = 16'd3536;
  localparam logic [15:0] OVH_LS_B12_US = 16'd4430;
  localparam logic [15:0] OVH_LS_B12P_US = 16'd4072;
  localparam logic [15:0] OVH_LS_C8_US = 16'd4521;
  localparam logic [15:0] OVH_LS_C12_US = 16'd5439;
  localparam logic [15:0] OVH_LS_C12P_US = 16'd4980;
  localparam logic [15:0] OVH_GR_FIXED_US = 16'd810;
  localparam logic [15:0] OVH_GR_B8_US = 16'd22285;
  localparam logic [15:0] OVH_GR_B12_US = 16'd28516;
  localparam logic [15:0] OVH_GR_B12P_US = 16'd48371;
  localparam logic [15:0] OVH_GR_C8_US = 16'd23273;
  localparam logic [15:0] OVH_GR_C12_US = 16'd30513;
  localparam logic [15:0] OVH_GR_C12P_US = 16'd61217;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXPOSE = 4'b0010,
    ST_READ = 4'b0100,
    ST_OVH = 4'b1000
  } ses_state_type;

  typedef struct packed {
    logic global_shutter;
    logic grr_mode;
    logic width_mode;
    logic [1:0] fmt;
    logic [1:0] variant;
    logic [11:0] height;
    logic [19:0] exposure_us;
  } ses_cfg_type;

endpackage

/* File: hw/ses_sequencer.sv */
// Shutter exposure sequencer: frame timing for global and rolling shutters.
// Assumes one AHB-Lite master, a frame trigger pin from outside the clock domain,
// and a 100 MHz hclk.
`timescale 1ns/1ns

// Operation
// - Global shutter: all lines start exposing together on the trigger.
// - Global shutter: all lines stop on timer end or trigger release in width mode.
// - Global shutter: line-by-line readout starts right after exposure ends.
// - Global shutter: exposure output spans first line start to last line end.
// - Sensor readout duration for current settings is readable.
// - Rolling shutter offers line-staggered and global-reset-release modes.
// - Line-staggered: lines reset one line-shift interval apart, top to bottom.
// - Line-shift interval depends on variant and pixel format depth.
// - Line-staggered: every line gets the programmed exposure time.
// - Each line reads out after its exposure, taking one line-shift interval.
// - Line-staggered readout total is shift times height plus overhead.
// - Reset runtime is shift times one less than the window height.
// - Total runtime is exposure plus total readout time.
// - Line-staggered: no flash window when exposure is below reset runtime.
// - Global-reset-release: all lines reset and expose together on trigger.
// - Global-reset-release: line ends staggered by shift after line one.
// - Global-reset-release readout total is shift times height plus its overhead.
// - Global-reset-release: exposure output follows line one exposure.
// - Global-reset-release: flash window opens right after the trigger.
// - Global-reset-release flash spans full exposure; line-staggered only part.
// - Flash window output exists in both rolling modes; lighting should use it.
// - Line-staggered flash opens after reset runtime, lasts exposure minus it.
// - Global-reset-release flash closes exposure time after the trigger.
// - Shutter runs in the host-selected mode.
module ses_sequencer #(
  parameter int US_CYCLES = ses_pkg::CYC_PER_US
) (
  input wire logic hclk, // Bus and sequencer clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size, word only.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic hreadyout, // Slave ready.
  output logic [31:0] hrdata, // Read data.
  output logic hresp, // Response, always OKAY.
  input wire logic frame_trig_in, // Frame start trigger pin.
  output logic exposure_active, // Exposure in progress.
  output logic flash_window // Flash window open.
);
  import ses_pkg::*;

  // ==========================================================================
  // Trigger pin synchroniser
  logic trig_s1_r, trig_s2_r, trig_s3_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_s3_r <= 1'b0;
    end else begin
      trig_s1_r <= frame_trig_in;
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
    end
  end
  wire trig_rise = trig_s2_r & ~trig_s3_r;

  // ==========================================================================
  // AHB-Lite slave
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  wire addr_phase = hsel & htrans[1] & hready;
  wire wr_ctrl = wr_pend_r && (wr_addr_r == ADDR_CTRL);
  wire wr_exposure = wr_pend_r && (wr_addr_r == ADDR_EXPOSURE);
  wire wr_height = wr_pend_r && (wr_addr_r == ADDR_HEIGHT);
  wire wr_status = wr_pend_r && (wr_addr_r == ADDR_STATUS);
  wire sw_trig = wr_ctrl & hwdata[CTRL_TRIG_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hreadyout_r <= 1'b1;
    end else begin
      wr_pend_r <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_r <= haddr[7:0];
      end
      hreadyout_r <= 1'b1;
    end
  end
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;

  // ==========================================================================
  // Configuration registers
  ses_cfg_type cfg_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r.global_shutter <= CTRL_RST[CTRL_GLOBAL_BIT];
      cfg_r.grr_mode <= CTRL_RST[CTRL_MODE_BIT];
      cfg_r.width_mode <= CTRL_RST[CTRL_WIDTH_BIT];
      cfg_r.fmt <= CTRL_RST[CTRL_FMT_LSB +: 2];
      cfg_r.variant <= CTRL_RST[CTRL_VAR_LSB +: 2];
      cfg_r.height <= HEIGHT_RST;
      cfg_r.exposure_us <= EXPOSURE_RST;
    end else begin
      if (wr_ctrl) begin
        cfg_r.global_shutter <= hwdata[CTRL_GLOBAL_BIT];
        cfg_r.grr_mode <= hwdata[CTRL_MODE_BIT];
        cfg_r.width_mode <= hwdata[CTRL_WIDTH_BIT];
        cfg_r.fmt <= hwdata[CTRL_FMT_LSB +: 2];
        cfg_r.variant <= hwdata[CTRL_VAR_LSB +: 2];
      end
      if (wr_exposure) begin
        cfg_r.exposure_us <= (hwdata[19:0] == 20'h0_0000) ? 20'h0_0001 : hwdata[19:0];
      end
      if (wr_height) begin
        cfg_r.height <= (hwdata[11:0] == 12'h000) ? 12'h001 : hwdata[11:0];
      end
    end
  end

  // ==========================================================================
  // Timing lookups and derived runtimes
  function automatic logic [15:0] shift_lookup(input logic [1:0] v, input logic [1:0] f);
    logic [15:0] r;
    r = SHIFT_FIXED_NS;
    if (v == 2'd1) begin
      r = (f == 2'd1) ? SHIFT_B12_NS : ((f == 2'd2) ? SHIFT_B12P_NS : SHIFT_B8_NS);
    end else if (v == 2'd2) begin
      r = (f == 2'd1) ? SHIFT_C12_NS : ((f == 2'd2) ? SHIFT_C12P_NS : SHIFT_C8_NS);
    end
    return r;
  endfunction

  function automatic logic [15:0] ovh_lookup(input logic g, input logic v1, input logic v2,
                                             input logic [1:0] f);
    logic [15:0] r;
    r = g ? OVH_GR_FIXED_US : OVH_LS_FIXED_US;
    if (v1) begin
      r = g ? ((f == 2'd1) ? OVH_GR_B12_US : ((f == 2'd2) ? OVH_GR_B12P_US : OVH_GR_B8_US))
            : ((f == 2'd1) ? OVH_LS_B12_US : ((f == 2'd2) ? OVH_LS_B12P_US : OVH_LS_B8_US));
    end else if (v2) begin
      r = g ? ((f == 2'd1) ? OVH_GR_C12_US : ((f == 2'd2) ? OVH_GR_C12P_US : OVH_GR_C8_US))
            : ((f == 2'd1) ? OVH_LS_C12_US : ((f == 2'd2) ? OVH_LS_C12P_US : OVH_LS_C8_US));
    end
    return r;
  endfunction

  // The global shutter has no preparation overhead after readout.
  wire [15:0] cur_shift = shift_lookup(cfg_r.variant, cfg_r.fmt);
  wire [15:0] cur_ovh = cfg_r.global_shutter ? 16'h0000
                      : ovh_lookup(cfg_r.grr_mode, cfg_r.variant == 2'd1, cfg_r.variant == 2'd2, cfg_r.fmt);
  wire [31:0] sensor_ro_ns = 32'(cur_shift) * 32'(cfg_r.height);
  wire [31:0] reset_rt_ns = 32'(cur_shift) * 32'(cfg_r.height - 12'h001);
  wire [31:0] total_ro_ns = sensor_ro_ns + 32'(cur_ovh) * 32'(NS_PER_US);
  wire [31:0] total_rt_ns = 32'(cfg_r.exposure_us) * 32'(NS_PER_US) + total_ro_ns;

  // ==========================================================================
  // Frame sequencer
  ses_state_type state_r, state_nxt;
  ses_cfg_type lat_r;
  logic [15:0] lat_shift_r, lat_ovh_r;
  logic lat_hw_r;
  logic [15:0] us_div_r;
  logic [19:0] us_cnt_r;
  logic [15:0] ro_acc_r, rs_acc_r;
  logic [11:0] ro_lines_r, rs_lines_r;
  logic rs_done_r, rs_done_nxt;
  logic miss_r;
  logic exp_r, flash_r;

  wire start = (state_r == ST_IDLE) && (trig_rise || sw_trig);
  wire us_tick = (us_div_r == 16'(US_CYCLES - 1));
  wire width_end = lat_r.global_shutter && lat_r.width_mode && lat_hw_r && !trig_s2_r;
  wire timer_end = us_tick && (us_cnt_r == lat_r.exposure_us - 20'h0_0001);
  wire expose_end = (state_r == ST_EXPOSE) &&
                    ((lat_r.global_shutter && lat_r.width_mode && lat_hw_r) ? width_end : timer_end);
  wire [16:0] ro_sum = {1'b0, ro_acc_r} + 17'(CLK_PERIOD_NS);
  wire ro_step = ro_sum >= {1'b0, lat_shift_r};
  wire ro_last = (state_r == ST_READ) && ro_step && (ro_lines_r == lat_r.height - 12'h001);
  wire ovh_done = (state_r == ST_OVH) && us_tick && (us_cnt_r == 20'(lat_ovh_r) - 20'h0_0001);
  wire [16:0] rs_sum = {1'b0, rs_acc_r} + 17'(CLK_PERIOD_NS);
  wire rs_step = rs_sum >= {1'b0, lat_shift_r};
  wire rs_active = (state_r != ST_IDLE) && !rs_done_r;
  wire phase_start = start || (state_nxt != state_r);
  wire ses_cfg_type lat_nxt = start ? cfg_r : lat_r;
  wire ls_nxt = !lat_nxt.global_shutter && !lat_nxt.grr_mode;
  wire miss_set = expose_end && !lat_r.global_shutter && !lat_r.grr_mode && !rs_done_nxt;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = ST_EXPOSE;
        end
      end
      ST_EXPOSE: begin
        if (expose_end) begin
          state_nxt = ST_READ;
        end
      end
      ST_READ: begin
        if (ro_last) begin
          state_nxt = (lat_ovh_r == 16'h0000) ? ST_IDLE : ST_OVH;
        end
      end
      ST_OVH: begin
        if (ovh_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // The reset sweep runs from the trigger, in parallel with the exposure.
  always_comb begin
    rs_done_nxt = rs_done_r;
    if (start) begin
      rs_done_nxt = (cfg_r.height == 12'h001);
    end else if (rs_active && rs_step && (rs_lines_r == lat_r.height - 12'h002)) begin
      rs_done_nxt = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      lat_r <= '0;
      lat_shift_r <= 16'h0000;
      lat_ovh_r <= 16'h0000;
      lat_hw_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (start) begin
        lat_r <= cfg_r;
        lat_shift_r <= cur_shift;
        lat_ovh_r <= cur_ovh;
        lat_hw_r <= trig_rise;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      us_div_r <= 16'h0000;
      us_cnt_r <= 20'h0_0000;
    end else if (phase_start) begin
      us_div_r <= 16'h0000;
      us_cnt_r <= 20'h0_0000;
    end else begin
      us_div_r <= us_tick ? 16'h0000 : us_div_r + 16'h0001;
      if (us_tick) begin
        us_cnt_r <= us_cnt_r + 20'h0_0001;
      end
    end
  end

  // Fractional line-shift timing: the residue carries over, so no drift builds up.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ro_acc_r <= 16'h0000;
      ro_lines_r <= 12'h000;
    end else if (state_r != ST_READ) begin
      ro_acc_r <= 16'h0000;
      ro_lines_r <= 12'h000;
    end else if (ro_step) begin
      ro_acc_r <= 16'(ro_sum - {1'b0, lat_shift_r});
      ro_lines_r <= ro_lines_r + 12'h001;
    end else begin
      ro_acc_r <= ro_sum[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rs_acc_r <= 16'h0000;
      rs_lines_r <= 12'h000;
      rs_done_r <= 1'b0;
    end else begin
      rs_done_r <= rs_done_nxt;
      if (start) begin
        rs_acc_r <= 16'h0000;
        rs_lines_r <= 12'h000;
      end else if (rs_active && rs_step) begin
        rs_acc_r <= 16'(rs_sum - {1'b0, lat_shift_r});
        rs_lines_r <= rs_lines_r + 12'h001;
      end else if (rs_active) begin
        rs_acc_r <= rs_sum[15:0];
      end
    end
  end

  // ==========================================================================
  // Outputs and status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exp_r <= 1'b0;
      flash_r <= 1'b0;
      miss_r <= 1'b0;
    end else begin
      exp_r <= (state_nxt == ST_EXPOSE);
      // Line-staggered opens once the last line is reset; reset-release opens at once.
      flash_r <= (state_nxt == ST_EXPOSE) && !lat_nxt.global_shutter &&
                 (lat_nxt.grr_mode || (ls_nxt && rs_done_nxt));
      if (miss_set) begin
        miss_r <= 1'b1;
      end else if (wr_status && hwdata[STAT_MISS_BIT]) begin
        miss_r <= 1'b0;
      end
    end
  end
  assign exposure_active = exp_r;
  assign flash_window = flash_r;

  // ==========================================================================
  // Read data
  logic [31:0] rd_mux;
  wire [7:0] ctrl_rd = {cfg_r.variant, cfg_r.fmt, 1'b0, cfg_r.width_mode, cfg_r.grr_mode, cfg_r.global_shutter};
  wire [3:0] stat_rd = {miss_r, flash_r, exp_r, state_r != ST_IDLE};
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      ADDR_CTRL: rd_mux = {24'h00_0000, ctrl_rd};
      ADDR_EXPOSURE: rd_mux = {12'h000, cfg_r.exposure_us};
      ADDR_HEIGHT: rd_mux = {20'h0_0000, cfg_r.height};
      ADDR_STATUS: rd_mux = {28'h000_0000, stat_rd};
      ADDR_SENSOR_RO: rd_mux = sensor_ro_ns;
      ADDR_TOTAL_RO: rd_mux = total_ro_ns;
      ADDR_RESET_RT: rd_mux = reset_rt_ns;
      ADDR_TOTAL_RT: rd_mux = total_rt_ns;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata_r <= rd_mux;
    end
  end
  assign hrdata = hrdata_r;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic [31:0] exp_cyc_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exp_cyc_r <= 32'h0000_0000;
    end else if (start) begin
      exp_cyc_r <= 32'h0000_0000;
    end else if (state_r == ST_EXPOSE) begin
      exp_cyc_r <= exp_cyc_r + 32'h0000_0001;
    end
  end

  sequence s_start_global;
    start && cfg_r.global_shutter;
  endsequence
  sequence s_start_grr;
    start && !cfg_r.global_shutter && cfg_r.grr_mode;
  endsequence

  gs_start_a: assert property (s_start_global |=> exposure_active && state_r == ST_EXPOSE)
    else $error("global shutter exposure did not start on trigger");
  gs_width_end_a: assert property ((state_r == ST_EXPOSE) && width_end |=> !exposure_active ##0 state_r == ST_READ)
    else $error("trigger release did not end global exposure");
  readout_next_a: assert property ($fell(exposure_active) |-> state_r == ST_READ && ro_lines_r == 12'h000)
    else $error("readout did not follow exposure end");
  exp_time_a: assert property ($fell(exposure_active) && !(lat_r.global_shutter && lat_r.width_mode && lat_hw_r)
    |-> exp_cyc_r == 32'(lat_r.exposure_us) * 32'(US_CYCLES))
    else $error("exposure length differs from setting");
  wire [31:0] lat_rst_ns = 32'(lat_shift_r) * 32'(lat_r.height - 12'h001);
  reset_rt_a: assert property ($rose(flash_window) && !lat_r.grr_mode |->
    exp_cyc_r == (lat_rst_ns + 32'(CLK_PERIOD_NS - 1)) / 32'(CLK_PERIOD_NS))
    else $error("line-staggered flash window did not open one reset runtime after the trigger");
  lines_bound_a: assert property (state_r == ST_READ |-> ro_lines_r < lat_r.height)
    else $error("readout line count overran window height");
  no_flash_a: assert property (exposure_active && !lat_r.global_shutter && !lat_r.grr_mode && !rs_done_r
    |-> !flash_window)
    else $error("flash window open before last line reset");
  grr_open_a: assert property (s_start_grr |=> flash_window && exposure_active)
    else $error("reset-release flash window did not open on trigger");
  grr_close_a: assert property (!lat_r.global_shutter && lat_r.grr_mode |-> flash_window == exposure_active)
    else $error("reset-release flash window not aligned with exposure");
  latch_hold_a: assert property (state_r != ST_IDLE && $past(state_r) != ST_IDLE |-> $stable(lat_r))
    else $error("frame settings changed during a frame");

endmodule

/* File: tb/ses_trig_flash_model.sv */
// Far-side model of the sequencer: frame trigger pulse source and flash lamp.
// Assumes the bench strobes fire for one cycle to request one trigger pulse.
`timescale 1ns/1ns
module ses_trig_flash_model (
  input wire logic hclk, // Clock.
  input wire logic hresetn, // Reset, active low.
  input wire logic fire, // Request one trigger pulse.
  input wire logic [15:0] fire_len, // Pulse length in cycles.
  input wire logic flash_window, // Flash window from the block.
  output logic frame_trig_in, // Trigger pin.
  output logic [15:0] lamp_cycles // Cycles the lamp was lit.
);
  logic [15:0] left_r;
  assign frame_trig_in = (left_r != 16'h0000);
  // ==========================================================================
  // Pulse source and lamp keyed on the flash window.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left_r <= 16'h0000;
      lamp_cycles <= 16'h0000;
    end else begin
      left_r <= fire ? fire_len : (frame_trig_in ? left_r - 16'h0001 : left_r);
      lamp_cycles <= lamp_cycles + {15'h0000, flash_window};
    end
  end
endmodule

/* File: tb/shutter_exposure_sequencer_test.sv */
// Self-checking bench for the shutter exposure sequencer.
// Assumes one AHB-Lite master here and a shortened microsecond count.
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (b)); end end
module shutter_exposure_sequencer_test;
  import ses_pkg::*;
  localparam int US = 2;
  localparam int LIMIT = 90000;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, frame_trig_in, exposure_active, flash_window, fire;
  logic [31:0] haddr, hwdata, hrdata, d, rnd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] fire_len, lamp_cycles, lamp0;
  int miscompares, checks_done, cyc, er, ew, fr, fw, el;

  ses_sequencer #(.US_CYCLES(US)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .frame_trig_in(frame_trig_in),
    .exposure_active(exposure_active), .flash_window(flash_window));
  ses_trig_flash_model far (.hclk(hclk), .hresetn(hresetn), .fire(fire), .fire_len(fire_len),
    .flash_window(flash_window), .frame_trig_in(frame_trig_in), .lamp_cycles(lamp_cycles));

  // ==========================================================================
  // Clock, cycle count and hang limit.
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      finish_test();
    end
  end

  // ==========================================================================
  // Expectation helpers.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] shift_ns(input logic [1:0] v, input logic [1:0] f);
    if (v == 2'd1) return 32'(f == 2'd1 ? SHIFT_B12_NS : f == 2'd2 ? SHIFT_B12P_NS : SHIFT_B8_NS);
    if (v == 2'd2) return 32'(f == 2'd1 ? SHIFT_C12_NS : f == 2'd2 ? SHIFT_C12P_NS : SHIFT_C8_NS);
    return 32'(SHIFT_FIXED_NS);
  endfunction
  function automatic logic [31:0] ovh_us(input logic [7:0] c);
    logic [1:0] f;
    f = c[5:4];
    if (c[0]) return 32'h0000_0000;
    if (c[7:6] == 2'd1 && !c[1]) return 32'(f == 2'd1 ? OVH_LS_B12_US : f == 2'd2 ? OVH_LS_B12P_US : OVH_LS_B8_US);
    if (c[7:6] == 2'd2 && !c[1]) return 32'(f == 2'd1 ? OVH_LS_C12_US : f == 2'd2 ? OVH_LS_C12P_US : OVH_LS_C8_US);
    if (c[7:6] == 2'd1) return 32'(f == 2'd1 ? OVH_GR_B12_US : f == 2'd2 ? OVH_GR_B12P_US : OVH_GR_B8_US);
    if (c[7:6] == 2'd2) return 32'(f == 2'd1 ? OVH_GR_C12_US : f == 2'd2 ? OVH_GR_C12P_US : OVH_GR_C8_US);
    return 32'(c[1] ? OVH_GR_FIXED_US : OVH_LS_FIXED_US);
  endfunction
  function automatic logic near(input int a, input int b, input int t);
    return (a >= b - t) && (a <= b + t);
  endfunction

  // ==========================================================================
  // Bus access: address phase held until hready, then data phase.
  task automatic bus_go(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk_calc(input logic [7:0] c, input logic [11:0] h, input logic [19:0] e);
    logic [31:0] s, o;
    bus_go(ADDR_EXPOSURE, 1'b1, {12'h000, e}, d);
    bus_go(ADDR_HEIGHT, 1'b1, {20'h0_0000, h}, d);
    bus_go(ADDR_CTRL, 1'b1, {24'h00_0000, c}, d);
    s = shift_ns(c[7:6], c[5:4]) * h;
    o = s + ovh_us(c) * NS_PER_US;
    bus_go(ADDR_SENSOR_RO, 1'b0, 32'h0000_0000, d); `CHK(d, s)
    bus_go(ADDR_TOTAL_RO, 1'b0, 32'h0000_0000, d); `CHK(d, o)
    bus_go(ADDR_RESET_RT, 1'b0, 32'h0000_0000, d); `CHK(d, s - shift_ns(c[7:6], c[5:4]))
    bus_go(ADDR_TOTAL_RT, 1'b0, 32'h0000_0000, d); `CHK(d, e * NS_PER_US + o)
  endtask
  // One frame at height 2: software trigger when pin is 0, else a pin pulse of that length.
  task automatic frame(input logic [7:0] c, input logic [19:0] e, input int pin);
    int t0;
    bus_go(ADDR_EXPOSURE, 1'b1, {12'h000, e}, d);
    bus_go(ADDR_CTRL, 1'b1, {24'h00_0000, c}, d);
    if (pin > 0) begin
      @(posedge hclk);
      fire <= 1'b1;
      fire_len <= 16'(pin);
      @(posedge hclk);
      fire <= 1'b0;
    end else begin
      bus_go(ADDR_CTRL, 1'b1, {24'h00_0000, c | 8'h08}, d);
    end
    t0 = cyc;
    lamp0 = lamp_cycles;
    er = -1;
    fr = -1;
    ew = 0;
    fw = 0;
    for (int i = 0; i <= e * US + 50; i++) begin
      if (i > 0) @(posedge hclk);
      #1;
      if (exposure_active === 1'b1) begin
        if (er < 0) er = i;
        ew++;
      end
      if (flash_window === 1'b1) begin
        if (fr < 0) fr = i;
        fw++;
      end
    end
    do bus_go(ADDR_STATUS, 1'b0, 32'h0000_0000, d); while (d[STAT_BUSY_BIT] !== 1'b0 && cyc < LIMIT);
    el = cyc - t0;
    if (pin > 0) `CHK(er >= 2 && er <= 5, 1'b1)
    else `CHK(er == 0, 1'b1)
    t0 = er + ew + 2 * shift_ns(2'd0, 2'd0) / CLK_PERIOD_NS + ovh_us(c) * US;
    `CHK(el >= t0 && el <= t0 + 8, 1'b1)
  endtask

  // ==========================================================================
  // Main sequence.
  task automatic finish_test;
    if (miscompares == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    {hresetn, hsel, hwrite, fire, htrans, haddr, hwdata, fire_len} = '0;
    hsize = 3'b010;
    cyc = 0;
    rnd = 32'h25C3_5A9A;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus_go(ADDR_CTRL, 1'b0, 32'h0000_0000, d); `CHK(d, 32'h0000_0000)
    `CHK({hresp, hreadyout}, 2'b01)
    bus_go(ADDR_EXPOSURE, 1'b0, 32'h0000_0000, d); `CHK(d, 32'h0000_0BB8)
    bus_go(ADDR_HEIGHT, 1'b0, 32'h0000_0000, d); `CHK(d, 32'h0000_0400)
    bus_go(8'h20, 1'b0, 32'h0000_0000, d); `CHK(d, 32'h0000_0000)
    bus_go(ADDR_HEIGHT, 1'b1, 32'h0000_0000, d);
    bus_go(ADDR_HEIGHT, 1'b0, 32'h0000_0000, d); `CHK(d, 32'h0000_0001)
    for (int k = 0; k < 16; k++) begin
      rnd = lfsr(rnd);
      chk_calc({k[3:2], k[1:0], 2'b00, rnd[1:0]}, rnd[13:2] | 12'h001, rnd[31:12] | 20'h0_0001);
    end
    bus_go(ADDR_HEIGHT, 1'b1, 32'h0000_0002, d);
    frame(8'h02, 20'h0_0005, 0);
    `CHK(ew, 10)
    `CHK(fr == er && fw == ew && lamp_cycles - lamp0 == 16'd10, 1'b1)
    frame(8'h00, 20'h0_07D0, 0);
    `CHK(ew, 4000)
    `CHK(near(fr - er, 3500, 2) && near(fw, 500, 2), 1'b1)
    frame(8'h00, 20'h0_0005, 0);
    `CHK(fw, 0)
    bus_go(ADDR_STATUS, 1'b0, 32'h0000_0000, d); `CHK(d[STAT_MISS_BIT], 1'b1)
    bus_go(ADDR_STATUS, 1'b1, 32'h0000_0008, d);
    bus_go(ADDR_STATUS, 1'b0, 32'h0000_0000, d); `CHK(d[STAT_MISS_BIT], 1'b0)
    frame(8'h05, 20'h0_03E8, 300);
    `CHK(near(ew, 300, 3) && fw == 0, 1'b1)
    frame(8'h01, 20'h0_0005, 3);
    `CHK(ew == 10 && fw == 0, 1'b1)
    finish_test();
  end
endmodule
